// ===== rtl/debug_port_key_access_control.sv
// key protected access control of the one wire debug port
// Operation
// - a protected feature unlocks only on an exact key match
// - three 64-bit keys, least significant byte first
// - erase key never clears an active programming key
// - erase key starts chip erase, lives until port disable or reset
// - row write key needs lock set, cleared by status write or reset
// - each accepted key shows in its key status bit
// - locked port refuses system bus outside row mode; unlocked port gets access unless system reset is held or sleep stops the clock
// - brownout detector forced active from fuse level during erase
// - programming flag sets after key plus reset issued and released while unlocked
// - row key plus reset pulse sets the row programming bit
// - row mode writes only the first 32 RAM bytes
// - on completion staged RAM bytes copy to the config row
// - tool sets write final, polls row bit, clears key, resets
// - row mode rejects every RAM read
// - each rising edge in the sync character emits one event
// - physical layer clock stays on in sleep while port enabled
// - no system bus access while sleep stops the processor clock
// - sleep indicator reads set in idle or deeper sleep
// - clock hold request resets to 1 and keeps system clock running while port enabled
// - key transfer takes 64 bits; info block returns up to 128 bits
`timescale 1ns/10ps
`include "key_access_regs.svh"

module debug_port_key_access_control
	import key_access_pkg::*;
#(
	// arbitrary neutral identification content
	parameter logic [127:0] INFO_BLOCK = 128'h3031323334353637_3839414243444546
) (
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire logic [4:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire key_stream_t KEY_IN,
	input wire logic INFO_RD,
	input wire logic [3:0] INFO_INDEX,
	output logic [7:0] INFO_DATA,
	input wire bus_req_t BUS_REQ,
	output logic BUS_GRANT,
	output logic BUS_REFUSE,
	input wire logic LOCKED,
	input wire logic ERASE_BUSY,
	output logic ERASE_START,
	input wire logic [2:0] BOD_FUSE_LEVEL,
	output logic [1:0] BOD_ACTIVE,
	output logic [2:0] BOD_LEVEL,
	output logic SYSTEM_RESET,
	output logic ROW_COPY_START,
	input wire logic ROW_COPY_DONE,
	input wire logic [1:0] SLEEP_MODE,
	output logic SYSCLK_HOLD,
	output logic PHY_CLK_RUN,
	input wire logic SYNC_ACTIVE,
	input wire logic SYNC_LINE,
	output logic SYNC_EDGE_EVENT
);

	logic [63:0] key_shift;
	logic [3:0] key_count;
	logic [63:0] key_full;
	logic key_take;
	logic hit_erase;
	logic hit_prog;
	logic hit_row;
	logic erase_key_flag;
	logic prog_key;
	logic row_write_key_flag;
	logic nvm_program_flag;
	logic row_prog_active;
	logic row_write_final;
	logic sysclk_hold_request;
	logic port_disable;
	sys_reset_t sys_state;
	logic rd_pend;
	logic sync_prev;
	logic wr_en;
	logic [7:0] wbyte;
	logic wr_key_status;
	logic wr_reset_req;
	logic wr_sys_ctrl;
	logic wr_port_ctrl;
	logic reset_issue;
	logic reset_release;
	logic sleep_indicator;
	logic [7:0] key_status_reg;
	logic [7:0] system_status_reg;
	logic [7:0] system_control_reg;
	logic [31:0] next_readdata;
	logic bus_ok;
	logic bus_pass;
	logic final_req;
	logic [2:0] word_sel;

	// key bytes arrive least significant first and shift in from the top
	assign key_full = {KEY_IN.data, key_shift[63:8]};
	assign key_take = KEY_IN.valid && !KEY_IN.start && key_count == `KA_KEY_LAST;
	assign hit_erase = key_take && key_full == `KA_KEY_ERASE;
	assign hit_prog = key_take && key_full == `KA_KEY_PROG;
	assign hit_row = key_take && key_full == `KA_KEY_ROW;

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			key_shift <= 64'h0;
			key_count <= 4'h0;
		end else if (KEY_IN.start) begin
			key_count <= 4'h0;
		end else if (KEY_IN.valid && key_count != `KA_KEY_BYTES) begin
			// bytes past the eighth are ignored
			key_shift <= key_full;
			key_count <= key_count + 4'h1;
		end
	end

	// register bus write decode, low byte lane carries every field
	assign wr_en = AVS_WRITE && AVS_BYTEENABLE[0];
	assign wbyte = AVS_WRITEDATA[7:0];
	// offsets are word aligned, the low two address bits are ignored
	assign word_sel = AVS_ADDRESS[4:2];
	assign wr_key_status = wr_en && word_sel == 3'(`KA_OFS_KEY_STATUS >> 2);
	assign wr_reset_req = wr_en && word_sel == 3'(`KA_OFS_RESET_REQ >> 2);
	assign wr_sys_ctrl = wr_en && word_sel == 3'(`KA_OFS_SYS_CTRL >> 2);
	assign wr_port_ctrl = wr_en && word_sel == 3'(`KA_OFS_PORT_CTRL >> 2);
	assign reset_issue = wr_reset_req && wbyte == `KA_RESET_SIG;
	assign reset_release = wr_reset_req && wbyte == `KA_RESET_CLEAR && sys_state == SYS_HELD;

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			sys_state <= SYS_RUN;
		end else begin
			unique case (sys_state)
				SYS_RUN: begin
					if (reset_issue) begin
						sys_state <= SYS_HELD;
					end
				end
				SYS_HELD: begin
					if (reset_release) begin
						sys_state <= SYS_RUN;
					end
				end
			endcase
		end
	end

	assign SYSTEM_RESET = sys_state == SYS_HELD;

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			port_disable <= 1'b0;
		end else if (wr_port_ctrl) begin
			port_disable <= wbyte[`KA_PC_DISABLE];
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			erase_key_flag <= 1'b0;
		end else if (hit_erase) begin
			erase_key_flag <= 1'b1;
		end else if (port_disable) begin
			erase_key_flag <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			ERASE_START <= 1'b0;
		end else begin
			ERASE_START <= hit_erase;
		end
	end

	// the erase key leaves this flag alone
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			prog_key <= 1'b0;
		end else if (hit_prog) begin
			prog_key <= 1'b1;
		end else if (reset_issue && nvm_program_flag) begin
			prog_key <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			row_write_key_flag <= 1'b0;
		end else if (hit_row) begin
			row_write_key_flag <= 1'b1;
		end else if (wr_key_status && wbyte[`KA_KS_ROW]) begin
			row_write_key_flag <= 1'b0;
		end
	end

	// set only by a released reset while the key is held and lock is clear
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			nvm_program_flag <= 1'b0;
		end else if (reset_release && prog_key && !LOCKED) begin
			nvm_program_flag <= 1'b1;
		end else if (reset_issue || !prog_key) begin
			nvm_program_flag <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			row_prog_active <= 1'b0;
		end else if (reset_release && row_write_key_flag && LOCKED) begin
			row_prog_active <= 1'b1;
		end else if (ROW_COPY_DONE && row_write_final) begin
			row_prog_active <= 1'b0;
		end
	end

	// a second final write during the copy does not restart it
	assign final_req = wr_sys_ctrl && wbyte[`KA_SC_FINAL] && row_prog_active;

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			row_write_final <= 1'b0;
		end else if (final_req) begin
			row_write_final <= 1'b1;
		end else if (ROW_COPY_DONE) begin
			row_write_final <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			ROW_COPY_START <= 1'b0;
		end else begin
			ROW_COPY_START <= final_req && !row_write_final;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			sysclk_hold_request <= `KA_SC_RESET;
		end else if (wr_sys_ctrl) begin
			sysclk_hold_request <= wbyte[`KA_SC_HOLD];
		end
	end

	assign SYSCLK_HOLD = sysclk_hold_request && !port_disable;
	assign PHY_CLK_RUN = !port_disable;
	assign sleep_indicator = SLEEP_MODE != `KA_SLEEP_NONE;

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			BOD_ACTIVE <= `KA_BOD_OFF;
		end else begin
			// forced on only for the span of the erase
			BOD_ACTIVE <= ERASE_BUSY ? `KA_BOD_ACTIVE : `KA_BOD_OFF;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			BOD_LEVEL <= 3'h0;
		end else begin
			BOD_LEVEL <= BOD_FUSE_LEVEL;
		end
	end

	// system bus gate: lock, row mode window, sleep without clock hold
	always_comb begin
		bus_ok = 1'b1;
		if (sleep_indicator && !SYSCLK_HOLD) begin
			bus_ok = 1'b0;
		end else if (row_prog_active) begin
			bus_ok = BUS_REQ.write && BUS_REQ.in_ram && BUS_REQ.addr < `KA_ROW_BYTES;
		end else if (LOCKED) begin
			bus_ok = 1'b0;
		end
	end

	// a held system reset refuses every access, whatever the key state
	assign bus_pass = bus_ok && !SYSTEM_RESET;
	assign BUS_GRANT = BUS_REQ.req && bus_pass;
	assign BUS_REFUSE = BUS_REQ.req && !bus_pass;

	// resets to the idle low line, so no false edge follows reset
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			sync_prev <= 1'b0;
		end else begin
			sync_prev <= SYNC_LINE;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			SYNC_EDGE_EVENT <= 1'b0;
		end else begin
			SYNC_EDGE_EVENT <= SYNC_ACTIVE && SYNC_LINE && !sync_prev;
		end
	end

	// info bytes stand until the next info read
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			INFO_DATA <= 8'h00;
		end else if (INFO_RD) begin
			INFO_DATA <= INFO_BLOCK[{INFO_INDEX, 3'h0} +: 8];
		end
	end

	always_comb begin
		key_status_reg = 8'h00;
		key_status_reg[`KA_KS_ROW] = row_write_key_flag;
		key_status_reg[`KA_KS_PROG] = prog_key;
		key_status_reg[`KA_KS_ERASE] = erase_key_flag;
	end

	always_comb begin
		system_status_reg = 8'h00;
		system_status_reg[`KA_SS_RSTSYS] = SYSTEM_RESET;
		system_status_reg[`KA_SS_SLEEP] = sleep_indicator;
		system_status_reg[`KA_SS_PROG] = nvm_program_flag;
		system_status_reg[`KA_SS_ROWPROG] = row_prog_active;
		system_status_reg[`KA_SS_LOCK] = LOCKED;
	end

	always_comb begin
		system_control_reg = 8'h00;
		system_control_reg[`KA_SC_FINAL] = row_write_final;
		system_control_reg[`KA_SC_HOLD] = sysclk_hold_request;
	end

	// readback mux, unmapped words read as zero
	always_comb begin
		next_readdata = 32'h0000_0000;
		unique case (word_sel)
			3'(`KA_OFS_KEY_STATUS >> 2): begin
				next_readdata = {24'h000000, key_status_reg};
			end
			3'(`KA_OFS_RESET_REQ >> 2): begin
				next_readdata = {31'h0000_0000, SYSTEM_RESET};
			end
			3'(`KA_OFS_SYS_CTRL >> 2): begin
				next_readdata = {24'h000000, system_control_reg};
			end
			3'(`KA_OFS_SYS_STATUS >> 2): begin
				next_readdata = {24'h000000, system_status_reg};
			end
			3'(`KA_OFS_PORT_CTRL >> 2): begin
				next_readdata = {31'h0000_0000, port_disable};
			end
			default: next_readdata = 32'h0000_0000;
		endcase
	end

	// reads take one wait cycle, writes complete at once
	// the answer edge clears the pending flag, so back to back reads each wait once
	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			rd_pend <= 1'b0;
			AVS_READDATA <= 32'h0000_0000;
		end else begin
			rd_pend <= AVS_READ && !rd_pend;
			if (AVS_READ && !rd_pend) begin
				AVS_READDATA <= next_readdata;
			end
		end
	end

	assign AVS_WAITREQUEST = AVS_READ && !rd_pend;

endmodule : debug_port_key_access_control

// ===== rtl/key_access_regs.svh
// register offsets, bit positions, key values and timing-free constants of the key access block
`ifndef KEY_ACCESS_REGS_SVH
`define KEY_ACCESS_REGS_SVH

`define KA_OFS_KEY_STATUS 5'h00
`define KA_OFS_RESET_REQ 5'h04
`define KA_OFS_SYS_CTRL 5'h08
`define KA_OFS_SYS_STATUS 5'h0C
`define KA_OFS_PORT_CTRL 5'h10

`define KA_KS_ROW 5
`define KA_KS_PROG 4
`define KA_KS_ERASE 3

`define KA_SS_RSTSYS 5
`define KA_SS_SLEEP 4
`define KA_SS_PROG 3
`define KA_SS_ROWPROG 2
`define KA_SS_LOCK 0

`define KA_SC_FINAL 1
`define KA_SC_HOLD 0
`define KA_SC_RESET 1'b1

`define KA_PC_DISABLE 0

`define KA_KEY_ERASE 64'h4E564D4572617365
`define KA_KEY_PROG 64'h4E564D50726F6720
`define KA_KEY_ROW 64'h4E564D5573267465

`define KA_RESET_SIG 8'h59
`define KA_RESET_CLEAR 8'h00

`define KA_KEY_BYTES 4'h8
`define KA_KEY_LAST 4'h7
`define KA_ROW_BYTES 16'h0020
`define KA_BOD_ACTIVE 2'h1
`define KA_BOD_OFF 2'h0
`define KA_SLEEP_NONE 2'h0

`endif

// ===== rtl/key_access_pkg.sv
// types shared by the key access block
package key_access_pkg;

	typedef struct packed {
		logic start;
		logic valid;
		logic [7:0] data;
	} key_stream_t;

	typedef struct packed {
		logic req;
		logic write;
		logic in_ram;
		logic [15:0] addr;
	} bus_req_t;

	typedef enum logic [1:0] {
		SYS_RUN = 2'b00,
		SYS_HELD = 2'b01
	} sys_reset_t;

endpackage : key_access_pkg

// ===== tb/key_access_props.sv
// port checker of the key access block
`timescale 1ns/10ps
`include "key_access_regs.svh"
module key_access_props
	import key_access_pkg::*;
(
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic AVS_WAITREQUEST,
	input wire bus_req_t BUS_REQ,
	input wire logic BUS_GRANT,
	input wire logic BUS_REFUSE,
	input wire logic LOCKED,
	input wire logic ERASE_BUSY,
	input wire logic [2:0] BOD_FUSE_LEVEL,
	input wire logic [1:0] BOD_ACTIVE,
	input wire logic [2:0] BOD_LEVEL,
	input wire logic SYSTEM_RESET,
	input wire logic [1:0] SLEEP_MODE,
	input wire logic SYSCLK_HOLD,
	input wire logic PHY_CLK_RUN,
	input wire logic SYNC_ACTIVE,
	input wire logic SYNC_LINE,
	input wire logic SYNC_EDGE_EVENT
);
	default clocking @(posedge CLOCK);
	endclocking
	default disable iff (SYS_RST);
	one_answer_a: assert property (BUS_REQ.req |-> BUS_GRANT != BUS_REFUSE)
		else $error("bus answer not exclusive");
	locked_refuse_a: assert property (BUS_REQ.req && LOCKED && !BUS_REQ.in_ram |-> BUS_REFUSE)
		else $error("locked access granted");
	sleep_refuse_a: assert property (BUS_REQ.req && SLEEP_MODE != 2'h0 && !SYSCLK_HOLD
		|-> BUS_REFUSE) else $error("access in stopped sleep");
	bod_force_a: assert property (ERASE_BUSY |=> BOD_ACTIVE == `KA_BOD_ACTIVE
		&& BOD_LEVEL == $past(BOD_FUSE_LEVEL)) else $error("brownout not forced");
	sync_event_a: assert property (SYNC_ACTIVE && $rose(SYNC_LINE) |=> SYNC_EDGE_EVENT)
		else $error("sync edge event missing");
	read_wait_a: assert property ($rose(AVS_READ) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
		else $error("read answer timing");
	reset_sig_a: assert property ($rose(SYSTEM_RESET)
		|-> $past(AVS_WRITE && AVS_WRITEDATA[7:0] == `KA_RESET_SIG)) else $error("reset without sig");
	phy_run_a: assert property ($fell(PHY_CLK_RUN) |-> $past(AVS_WRITE))
		else $error("link clock stopped");
endmodule : key_access_props

// ===== tb/nvm_side_model.sv
// memory side model: chip erase busy for lag+1 cycles, config row copy done lag+2 cycles after its start
`timescale 1ns/10ps
module nvm_side_model (
	input wire logic CLOCK,
	input wire logic [3:0] lag,
	input wire logic ERASE_START,
	input wire logic ROW_COPY_START,
	output logic LOCKED = 1'b1,
	output logic ERASE_BUSY = 1'b0,
	output logic ROW_COPY_DONE = 1'b0
);
	int e = 0;
	int r = 0;
	// lock bits are nonvolatile, a system reset leaves them alone
	always @(posedge CLOCK) begin
		if (ERASE_START)
			e <= lag + 2;
		else if (e > 0)
			e <= e - 1;
		ERASE_BUSY <= e > 1;
		if (e == 1)
			LOCKED <= 1'b0;
		if (ROW_COPY_START)
			r <= lag + 2;
		else if (r > 0)
			r <= r - 1;
		ROW_COPY_DONE <= r == 1;
	end
endmodule : nvm_side_model

// ===== tb/test_debug_port_key_access_control.sv
// self-checking bench of the key access block
`timescale 1ns/10ps
`include "key_access_regs.svh"
module test_debug_port_key_access_control
	import key_access_pkg::*;
;
	localparam logic [127:0] INFO = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
	localparam logic [4:0] KS = `KA_OFS_KEY_STATUS;
	localparam logic [4:0] RR = `KA_OFS_RESET_REQ;
	localparam logic [4:0] SC = `KA_OFS_SYS_CTRL;
	localparam logic [4:0] SS = `KA_OFS_SYS_STATUS;
	logic CLOCK = 0, SYS_RST = 1, AVS_READ = 0, AVS_WRITE = 0, INFO_RD = 0;
	logic SYNC_ACTIVE = 0, SYNC_LINE = 0, AVS_WAITREQUEST, BUS_GRANT, BUS_REFUSE, LOCKED;
	logic ERASE_BUSY, ERASE_START, SYSTEM_RESET, ROW_COPY_START, ROW_COPY_DONE, SYSCLK_HOLD;
	logic PHY_CLK_RUN, SYNC_EDGE_EVENT;
	logic [31:0] AVS_WRITEDATA = 0, AVS_READDATA, d;
	logic [4:0] AVS_ADDRESS = 0;
	logic [3:0] AVS_BYTEENABLE = 4'hF, INFO_INDEX = 0, lag = 0;
	logic [2:0] BOD_FUSE_LEVEL = 0, BOD_LEVEL;
	logic [1:0] SLEEP_MODE = 0, BOD_ACTIVE;
	logic [7:0] INFO_DATA;
	key_stream_t KEY_IN = '0;
	bus_req_t BUS_REQ = '0;
	int n_errors = 0, num_checks = 0, n_ev = 0, t, n;
	debug_port_key_access_control #(.INFO_BLOCK(INFO)) dut (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
		.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
		.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
		.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .KEY_IN(KEY_IN),
		.INFO_RD(INFO_RD), .INFO_INDEX(INFO_INDEX), .INFO_DATA(INFO_DATA),
		.BUS_REQ(BUS_REQ), .BUS_GRANT(BUS_GRANT), .BUS_REFUSE(BUS_REFUSE), .LOCKED(LOCKED),
		.ERASE_BUSY(ERASE_BUSY), .ERASE_START(ERASE_START),
		.BOD_FUSE_LEVEL(BOD_FUSE_LEVEL), .BOD_ACTIVE(BOD_ACTIVE), .BOD_LEVEL(BOD_LEVEL),
		.SYSTEM_RESET(SYSTEM_RESET), .ROW_COPY_START(ROW_COPY_START),
		.ROW_COPY_DONE(ROW_COPY_DONE), .SLEEP_MODE(SLEEP_MODE), .SYSCLK_HOLD(SYSCLK_HOLD),
		.PHY_CLK_RUN(PHY_CLK_RUN), .SYNC_ACTIVE(SYNC_ACTIVE), .SYNC_LINE(SYNC_LINE),
		.SYNC_EDGE_EVENT(SYNC_EDGE_EVENT));
	nvm_side_model nvm (.CLOCK(CLOCK), .lag(lag), .ERASE_START(ERASE_START),
		.ROW_COPY_START(ROW_COPY_START), .LOCKED(LOCKED), .ERASE_BUSY(ERASE_BUSY),
		.ROW_COPY_DONE(ROW_COPY_DONE));
	initial forever #5 CLOCK = ~CLOCK;
	always @(negedge CLOCK)
		if (SYNC_EDGE_EVENT === 1'b1)
			n_ev++;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask : chk
	// request held until the edge that finds waitrequest low
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] v);
		@(posedge CLOCK);
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= {24'h0, v};
		AVS_WRITE <= w;
		AVS_READ <= !w;
		t = 0;
		do begin
			@(posedge CLOCK);
			t++;
		end while (AVS_WAITREQUEST !== 1'b0 && t < 60);
		if (AVS_WAITREQUEST !== 1'b0)
			n_errors++;
		d = AVS_READDATA;
		AVS_WRITE <= 0;
		AVS_READ <= 0;
	endtask : bus
	task automatic rc(input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, 8'h00);
		chk(d, e);
	endtask : rc
	task automatic poll(input int b);
		n = 0;
		do begin
			bus(1'b0, SS, 8'h00);
			n++;
		end while (d[b] !== 1'b0 && n < 40);
		if (d[b] !== 1'b0)
			n_errors++;
	endtask : poll
	task automatic key(input logic [63:0] k, input int m);
		@(posedge CLOCK);
		KEY_IN <= {2'b10, 8'h00};
		for (int i = 0; i < m; i++) begin
			@(posedge CLOCK);
			KEY_IN <= {2'b01, k[i*8 +: 8]};
		end
		@(posedge CLOCK);
		KEY_IN <= '0;
	endtask : key
	task automatic req(input logic w, input logic r, input logic [15:0] a, input logic g);
		@(posedge CLOCK);
		BUS_REQ <= {1'b1, w, r, a};
		@(negedge CLOCK);
		chk({30'h0, BUS_GRANT, BUS_REFUSE}, {30'h0, g, !g});
		@(posedge CLOCK);
		BUS_REQ <= '0;
	endtask : req
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out
	initial begin
		void'($urandom(32'h6e4d1432));
		lag = 4'($urandom_range(0, 9));
		BOD_FUSE_LEVEL = 3'($urandom);
		repeat (12) @(posedge CLOCK);
		SYS_RST <= 0;
		rc(KS, 0);
		rc(SC, 1);
		rc(SS, 1);
		rc(5'h14, 0);
		req(0, 0, 16'($urandom), 0);
		key(`KA_KEY_ERASE ^ (64'h1 << $urandom_range(0, 63)), 8);
		key(`KA_KEY_PROG, 7);
		rc(KS, 0);
		$display("wrong keys done");
		key(`KA_KEY_ROW, 8);
		rc(KS, 32'h20);
		bus(1, RR, `KA_RESET_SIG);
		rc(SS, 32'h21);
		bus(1, RR, `KA_RESET_CLEAR);
		rc(SS, 32'h05);
		req(1, 1, 16'($urandom_range(0, 31)), 1);
		req(1, 1, 16'($urandom_range(32, 65535)), 0);
		req(0, 1, 16'($urandom_range(0, 31)), 0);
		bus(1, SC, 8'h03);
		poll(`KA_SS_ROWPROG);
		chk(d, 32'h01);
		bus(1, KS, 8'h20);
		rc(KS, 0);
		$display("row write done");
		key(`KA_KEY_ERASE, 8);
		bus(1, RR, `KA_RESET_SIG);
		bus(1, RR, `KA_RESET_CLEAR);
		poll(`KA_SS_LOCK);
		chk(d, 0);
		key(`KA_KEY_PROG, 8);
		key(`KA_KEY_ERASE, 8);
		rc(KS, 32'h18);
		bus(1, RR, `KA_RESET_SIG);
		bus(1, RR, `KA_RESET_CLEAR);
		rc(SS, 32'h08);
		req(0, 0, 16'($urandom), 1);
		bus(1, RR, `KA_RESET_SIG);
		rc(KS, 32'h08);
		bus(1, RR, `KA_RESET_CLEAR);
		key(`KA_KEY_ROW, 8);
		bus(1, RR, `KA_RESET_SIG);
		bus(1, RR, `KA_RESET_CLEAR);
		rc(SS, 0);
		bus(1, KS, 8'h20);
		$display("erase and program done");
		@(posedge CLOCK);
		SLEEP_MODE <= 2'($urandom_range(1, 3));
		rc(SS, 32'h10);
		req(0, 0, 16'($urandom), 1);
		bus(1, SC, 8'h00);
		req(0, 0, 16'($urandom), 0);
		chk({31'h0, SYSCLK_HOLD}, 0);
		bus(1, SC, 8'h01);
		@(posedge CLOCK);
		SLEEP_MODE <= 0;
		n = $urandom_range(2, 5);
		SYNC_ACTIVE <= 1;
		repeat (n) begin
			@(posedge CLOCK);
			SYNC_LINE <= 1;
			repeat ($urandom_range(1, 3)) @(posedge CLOCK);
			SYNC_LINE <= 0;
		end
		@(posedge CLOCK);
		SYNC_ACTIVE <= 0;
		SYNC_LINE <= 1;
		repeat (3) @(posedge CLOCK);
		SYNC_LINE <= 0;
		chk(n_ev, n);
		for (int i = 0; i < 16; i++) begin
			@(posedge CLOCK);
			INFO_RD <= 1;
			INFO_INDEX <= 4'(i);
			@(posedge CLOCK);
			INFO_RD <= 0;
			@(negedge CLOCK);
			chk({24'h0, INFO_DATA}, {24'h0, INFO[i*8 +: 8]});
		end
		$display("sleep sync info done");
		bus(1, `KA_OFS_PORT_CTRL, 8'h01);
		rc(KS, 0);
		chk({31'h0, PHY_CLK_RUN}, 0);
		bus(1, `KA_OFS_PORT_CTRL, 8'h00);
		key(`KA_KEY_PROG, 8);
		@(posedge CLOCK);
		SYS_RST <= 1;
		repeat (2) @(posedge CLOCK);
		SYS_RST <= 0;
		rc(KS, 0);
		rc(SC, 1);
		$display("disable and reset done");
		close_out();
	end
	// the whole sequence needs well under 4000 cycles
	initial begin
		#100us;
		n_errors++;
		close_out();
	end
endmodule : test_debug_port_key_access_control
bind debug_port_key_access_control key_access_props props (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
	.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
	.AVS_WAITREQUEST(AVS_WAITREQUEST), .BUS_REQ(BUS_REQ), .BUS_GRANT(BUS_GRANT),
	.BUS_REFUSE(BUS_REFUSE), .LOCKED(LOCKED), .ERASE_BUSY(ERASE_BUSY),
	.BOD_FUSE_LEVEL(BOD_FUSE_LEVEL), .BOD_ACTIVE(BOD_ACTIVE), .BOD_LEVEL(BOD_LEVEL),
	.SYSTEM_RESET(SYSTEM_RESET), .SLEEP_MODE(SLEEP_MODE), .SYSCLK_HOLD(SYSCLK_HOLD),
	.PHY_CLK_RUN(PHY_CLK_RUN), .SYNC_ACTIVE(SYNC_ACTIVE), .SYNC_LINE(SYNC_LINE),
	.SYNC_EDGE_EVENT(SYNC_EDGE_EVENT));
